// *** ccdrt_pkg.sv ***
// constants and carrier types for the sensor readout sequencer
`default_nettype none
package ccdrt_pkg;

  // system clock
  localparam int CLK_NS    = 25;

  // shutter, phase-one transfer and row transfer times
  localparam int SHUT_NS   = 1000;
  localparam int SHUT_CYC  = (SHUT_NS + CLK_NS - 1) / CLK_NS;
  localparam int XFER_NS   = 2500;
  localparam int XFER_CYC  = (XFER_NS + CLK_NS - 1) / CLK_NS;
  localparam int ROW_NS    = 1200;
  localparam int ROW_CYC   = (ROW_NS + CLK_NS - 1) / CLK_NS;

  // exit pulse width floor, checked against the pixel pattern
  localparam int EXIT_NS   = 12;
  localparam int EXIT_CYC  = (EXIT_NS + CLK_NS - 1) / CLK_NS;

  // part sense enable window during initialisation
  localparam int SENSE_NS  = 2000;
  localparam int SENSE_CYC = (SENSE_NS + CLK_NS - 1) / CLK_NS;

  // pixel pattern: clocks per pixel and phase positions
  localparam int PIX_CLK   = 4;
  localparam logic [1:0] PH_B_START = 2'h2;
  localparam logic [1:0] PH_EXIT    = 2'h3;
  localparam logic [1:0] PH_LAST    = 2'h3;

  // line geometry in horizontal cycles
  localparam int LINE_CYC  = 3084;
  localparam int DARK_CYC  = 12;
  localparam int ACT_CYC   = 24;
  localparam int ROUTE_DLY = 28;

  // routing threshold
  localparam int THRESH_E  = 150;
  localparam int THRESH_UV = 930;

  // horizontal and switch gates
  typedef struct packed {
    logic ha;
    logic hb;
    logic hsa;
    logic hsb;
    logic last;
    logic fg_exit;
    logic fg_reset;
    logic lg_sw;
    logic mu_sw;
  } ccdrt_hgate_type;

  // shutter and vertical gates
  typedef struct packed {
    logic shutter;
    logic v1_top;
    logic v1_bottom;
    logic row_xfer;
  } ccdrt_vgate_type;

  // sequencer status
  typedef struct packed {
    logic busy;
    logic frame_done;
    logic dark;
    logic active;
  } ccdrt_stat_type;

  typedef enum logic [2:0] {
    ST_INIT, ST_IDLE, ST_SHUT, ST_EXPO, ST_XFER, ST_ROW, ST_LINE
  } ccdrt_state_type;

endpackage
`default_nettype wire

// *** ccdrt_ctrl.sv ***
// readout sequencer and sample fifo for an interline multiplying sensor
//
// What this block does
// - shutter pulse high at least 1 us
// - horizontal clocks stopped during shutter pulse
// - phase-one high at least 2.5 us
// - row transfer parks phase a high, b low
// - dark after 12, active after 24 more
// - reset pulse covers whole exit pulse
// - exit pulse at least 12 ns
// - exit rises after storage a falls
// - below threshold goes to multiplier
// - routing applied 28 cycles after sensing
// - multiplier route: switch gate follows phase b
// - low-gain route: switch gate follows storage b
// - part sense read once, then disabled
// - no multiplier clocking while shutter high
// - every line exactly 3084 cycles
`timescale 1ns/100ps
`default_nettype none

module ccdrt_fifo #(
  parameter int WIDTH = 16,
  parameter int DEPTH = 8
) (
  // clock and reset
  input  wire logic             clk_in,
  input  wire logic             rst_in,
  // filling side
  input  wire logic [WIDTH-1:0] in_data_in,
  input  wire logic             in_valid_in,
  output var  logic             in_ready_out,
  // draining side
  output var  logic [WIDTH-1:0] out_data_out,
  output var  logic             out_valid_out,
  input  wire logic             out_ready_in
);
  localparam int AW = $clog2(DEPTH);

  if (DEPTH < 2 || (1 << AW) != DEPTH) begin : g_chk
    $error("fifo depth must be a power of two");
  end

  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0]    wr_ptr_reg;
  logic [AW-1:0]    rd_ptr_reg;
  logic [AW:0]      count_reg;
  logic [AW:0]      count_next;
  logic             push;
  logic             pop;

  // handshakes; ready is registered, so it lags a pop by one cycle
  assign push          = in_valid_in & in_ready_out;
  assign pop           = out_ready_in & out_valid_out;
  assign out_valid_out = (count_reg != '0);
  assign out_data_out  = mem[rd_ptr_reg];
  assign count_next    = count_reg + {{AW{1'b0}}, push}
                       - {{AW{1'b0}}, pop};

  // depth is small, so the words sit in flops rather than a ram;
  // storage has no reset, only pointers, count and ready do
  always_ff @(posedge clk_in) begin
    if (push) begin
      mem[wr_ptr_reg] <= in_data_in;
    end
  end

  // pointers, occupancy and the registered ready
  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      wr_ptr_reg   <= '0;
      rd_ptr_reg   <= '0;
      count_reg    <= '0;
      in_ready_out <= 1'b0;
    end else begin
      wr_ptr_reg   <= wr_ptr_reg + AW'(push);
      rd_ptr_reg   <= rd_ptr_reg + AW'(pop);
      count_reg    <= count_next;
      in_ready_out <= (count_next < (AW+1)'(DEPTH));
    end
  end
endmodule // ccdrt_fifo

module ccdrt_ctrl #(
  parameter int          SAMPLE_W      = 16,
  parameter int          FIFO_DEPTH    = 8,
  parameter int          ROWS          = 16,
  parameter int          EXPOSE_CYCLES = 40000,
  parameter logic [15:0] THRESH_CODE   = 16'h03A2
) (
  // clock and reset
  input  wire logic                    CLOCK_IN,
  input  wire logic                    RST_IN,
  // frame request
  input  wire logic                    START_IN,
  // samples from the analog front end
  input  wire logic [SAMPLE_W-1:0]     SAMPLE_IN,
  input  wire logic                    SAMPLE_VALID_IN,
  output var  logic                    SAMPLE_READY_OUT,
  // sensor gates
  output var  ccdrt_pkg::ccdrt_vgate_type VGATE_OUT,
  output var  ccdrt_pkg::ccdrt_hgate_type HGATE_OUT,
  output var  logic                    MULT_CLOCK_EN_OUT,
  output var  logic                    PART_SENSE_EN_OUT,
  // status
  output var  ccdrt_pkg::ccdrt_stat_type STATUS_OUT
);
  // the dwell timer is wide enough for long exposures at this clock;
  // the row counter bounds the frame height accepted below
  localparam int TW = 32;
  localparam int RW = 16;

  if (SAMPLE_W < 16 || ROWS < 1 || ROWS >= 65536 ||
      EXPOSE_CYCLES < 1 || ccdrt_pkg::PIX_CLK != 4 ||
      ccdrt_pkg::EXIT_CYC > 1) begin : g_chk
    $error("unsupported sequencer parameters");
  end

  ccdrt_pkg::ccdrt_state_type state_reg;
  ccdrt_pkg::ccdrt_state_type state_next;
  logic [TW-1:0]         timer_reg;
  logic [TW-1:0]         timer_next;
  logic [RW-1:0]         row_reg;
  logic [RW-1:0]         row_next;
  logic [1:0]            phase_reg;
  logic [11:0]           pix_reg;
  logic [ccdrt_pkg::ROUTE_DLY-1:0] route_reg;
  logic                  timer_done;
  logic                  in_line;
  logic                  pix_end;
  logic                  line_end;
  logic                  route_mult;
  logic                  decide_mult;
  logic [SAMPLE_W-1:0]   smp_data;
  logic                  smp_valid;
  logic                  smp_pop;
  logic                  sense_on;
  ccdrt_pkg::ccdrt_vgate_type vg_next;
  ccdrt_pkg::ccdrt_hgate_type hg_next;
  ccdrt_pkg::ccdrt_stat_type  st_next;

  // sample buffer; draining stalls whenever clocking stops
  ccdrt_fifo #(
    .WIDTH (SAMPLE_W),
    .DEPTH (FIFO_DEPTH)
  ) u_fifo (
    .clk_in        (CLOCK_IN),
    .rst_in        (RST_IN),
    .in_data_in    (SAMPLE_IN),
    .in_valid_in   (SAMPLE_VALID_IN),
    .in_ready_out  (SAMPLE_READY_OUT),
    .out_data_out  (smp_data),
    .out_valid_out (smp_valid),
    .out_ready_in  (smp_pop)
  );

  // pixel and line decode
  assign timer_done = (timer_reg == '0);
  assign in_line    = (state_reg == ccdrt_pkg::ST_LINE);
  assign pix_end    = in_line & (phase_reg == ccdrt_pkg::PH_LAST);
  assign line_end   = pix_end &
                      (pix_reg == 12'(ccdrt_pkg::LINE_CYC - 1));
  assign smp_pop    = pix_end;
  // a missing sample routes low-gain so the multiplier never overfills
  assign decide_mult = smp_valid &
                       (smp_data < SAMPLE_W'(THRESH_CODE));
  assign route_mult = route_reg[ccdrt_pkg::ROUTE_DLY-1];
  assign sense_on   = (state_reg == ccdrt_pkg::ST_INIT);

  // state sequencing and dwell timer; each dwell loads one less than
  // its count because the load edge is already the first cycle of the
  // new state
  always_comb begin
    state_next = state_reg;
    timer_next = timer_done ? '0 : timer_reg - TW'(1);
    row_next   = row_reg;
    unique case (state_reg)
      ccdrt_pkg::ST_INIT: begin
        if (timer_done) begin
          state_next = ccdrt_pkg::ST_IDLE;
        end
      end
      ccdrt_pkg::ST_IDLE: begin
        if (START_IN) begin
          state_next = ccdrt_pkg::ST_SHUT;
          timer_next = TW'(ccdrt_pkg::SHUT_CYC - 1);
        end
      end
      ccdrt_pkg::ST_SHUT: begin
        if (timer_done) begin
          state_next = ccdrt_pkg::ST_EXPO;
          timer_next = TW'(EXPOSE_CYCLES - 1);
        end
      end
      ccdrt_pkg::ST_EXPO: begin
        if (timer_done) begin
          // prior frame left the vertical register empty
          state_next = ccdrt_pkg::ST_XFER;
          timer_next = TW'(ccdrt_pkg::XFER_CYC - 1);
        end
      end
      ccdrt_pkg::ST_XFER: begin
        if (timer_done) begin
          state_next = ccdrt_pkg::ST_ROW;
          timer_next = TW'(ccdrt_pkg::ROW_CYC - 1);
          row_next   = RW'(ROWS - 1);
        end
      end
      ccdrt_pkg::ST_ROW: begin
        if (timer_done) begin
          state_next = ccdrt_pkg::ST_LINE;
        end
      end
      ccdrt_pkg::ST_LINE: begin
        if (line_end) begin
          if (row_reg == '0) begin
            state_next = ccdrt_pkg::ST_IDLE;
          end else begin
            state_next = ccdrt_pkg::ST_ROW;
            timer_next = TW'(ccdrt_pkg::ROW_CYC - 1);
            row_next   = row_reg - RW'(1);
          end
        end
      end
    endcase
  end

  // vertical and shutter gate values; the drivers follow the state one
  // clock late, so the far side only ever sees registered levels
  always_comb begin
    vg_next           = '0;
    vg_next.shutter   = (state_reg == ccdrt_pkg::ST_SHUT);
    vg_next.v1_top    = (state_reg == ccdrt_pkg::ST_XFER);
    vg_next.v1_bottom = (state_reg == ccdrt_pkg::ST_XFER);
    vg_next.row_xfer  = (state_reg == ccdrt_pkg::ST_ROW);
  end

  // horizontal pattern: a high for phases 0-1, b high for 2-3
  // at this clock a pixel takes 100 ns; the exit pulse gets one full
  // clock, well above its floor, and waits a clock after storage a
  // falls so that the falling storage edge has time to settle
  always_comb begin
    hg_next = '0;
    if (in_line) begin
      hg_next.ha       = (phase_reg < ccdrt_pkg::PH_B_START);
      hg_next.hb       = (phase_reg >= ccdrt_pkg::PH_B_START);
      hg_next.hsa      = hg_next.ha;
      hg_next.hsb      = hg_next.hb;
      // last gate falls at the pixel end: packet sensed there
      hg_next.last     = hg_next.hb;
      // exit one clock after storage a falls, reset spans it
      hg_next.fg_exit  = (phase_reg == ccdrt_pkg::PH_EXIT);
      hg_next.fg_reset = hg_next.hb;
      hg_next.mu_sw    = route_mult & hg_next.hb;
      hg_next.lg_sw    = ~route_mult & hg_next.hsb;
    end else begin
      // stopped: a parked high, b low, both switches grounded
      hg_next.ha  = 1'b1;
      hg_next.hsa = 1'b1;
      hg_next.mu_sw = 1'b0;
      hg_next.lg_sw = 1'b0;
    end
  end

  // status flags; dark and active windows count pixels into the line
  always_comb begin
    st_next            = '0;
    st_next.busy       = (state_reg != ccdrt_pkg::ST_IDLE);
    st_next.frame_done = line_end & (row_reg == '0);
    st_next.dark       = in_line &
                         (pix_reg >= 12'(ccdrt_pkg::DARK_CYC)) &
                         (pix_reg < 12'(ccdrt_pkg::DARK_CYC +
                                        ccdrt_pkg::ACT_CYC));
    st_next.active     = in_line &
                         (pix_reg >= 12'(ccdrt_pkg::DARK_CYC +
                                         ccdrt_pkg::ACT_CYC));
  end

  // sequencer registers
  always_ff @(posedge CLOCK_IN or posedge RST_IN) begin
    if (RST_IN) begin
      state_reg <= ccdrt_pkg::ST_INIT;
      timer_reg <= TW'(ccdrt_pkg::SENSE_CYC - 1);
      row_reg   <= '0;
    end else begin
      state_reg <= state_next;
      timer_reg <= timer_next;
      row_reg   <= row_next;
    end
  end

  // pixel phase and line position; both restart at each line, which
  // keeps every line the same length even after an aborted one
  always_ff @(posedge CLOCK_IN or posedge RST_IN) begin
    if (RST_IN) begin
      phase_reg <= '0;
      pix_reg   <= '0;
    end else if (!in_line || line_end) begin
      phase_reg <= '0;
      pix_reg   <= '0;
    end else begin
      phase_reg <= phase_reg + 2'h1;
      pix_reg   <= pix_end ? pix_reg + 12'h001 : pix_reg;
    end
  end

  // routing decisions advance once per horizontal cycle; contents are
  // kept across row transfers, so the last decisions of one line land
  // on the first packets of the next, as the switch delay demands
  always_ff @(posedge CLOCK_IN or posedge RST_IN) begin
    if (RST_IN) begin
      route_reg <= '0;
    end else if (pix_end) begin
      route_reg <= {route_reg[ccdrt_pkg::ROUTE_DLY-2:0],
                    decide_mult};
    end
  end

  // registered outputs; every pin leaves a flip-flop so that gate
  // edges carry no decode glitch into the sensor drivers
  always_ff @(posedge CLOCK_IN or posedge RST_IN) begin
    if (RST_IN) begin
      VGATE_OUT         <= '0;
      HGATE_OUT         <= '0;
      MULT_CLOCK_EN_OUT <= 1'b0;
      PART_SENSE_EN_OUT <= 1'b0;
      STATUS_OUT        <= '0;
    end else begin
      VGATE_OUT         <= vg_next;
      HGATE_OUT         <= hg_next;
      // shutter is never high while the line runs
      MULT_CLOCK_EN_OUT <= in_line;
      PART_SENSE_EN_OUT <= sense_on;
      STATUS_OUT        <= st_next;
    end
  end
endmodule // ccdrt_ctrl
`default_nettype wire

// *** ccdrt_ctrl_asserts.sv ***
// port checker for the readout sequencer
`timescale 1ns/100ps
`default_nettype none
module ccdrt_ctrl_chk (
  // clock and reset
  input wire logic                       CLOCK_IN,
  input wire logic                       RST_IN,
  // gate drive
  input wire ccdrt_pkg::ccdrt_vgate_type VGATE_OUT,
  input wire ccdrt_pkg::ccdrt_hgate_type HGATE_OUT,
  input wire logic                       MULT_CLOCK_EN_OUT,
  input wire logic                       PART_SENSE_EN_OUT
);
  int sh_cnt;
  int v1_cnt;
  int ps_cnt;
  default clocking cb @(posedge CLOCK_IN);
  endclocking
  default disable iff (RST_IN);
  // pulse widths; sense total never clears, so a second window shows
  always_ff @(posedge CLOCK_IN or posedge RST_IN) begin
    if (RST_IN) begin
      sh_cnt <= 0;
      v1_cnt <= 0;
      ps_cnt <= 0;
    end else begin
      sh_cnt <= VGATE_OUT.shutter ? sh_cnt + 1 : 0;
      v1_cnt <= VGATE_OUT.v1_top ? v1_cnt + 1 : 0;
      ps_cnt <= PART_SENSE_EN_OUT ? ps_cnt + 1 : ps_cnt;
    end
  end
  // second half of a horizontal cycle, and the exit pulse
  sequence b_half_s;
    (HGATE_OUT.hb && !HGATE_OUT.ha) [*2];
  endsequence
  sequence exit_s;
    HGATE_OUT.fg_exit ##1 !HGATE_OUT.fg_exit;
  endsequence
  shut_width_a: assert property ($fell(VGATE_OUT.shutter) |->
    sh_cnt >= ccdrt_pkg::SHUT_CYC) else $error("short shutter");
  shut_quiet_a: assert property (VGATE_OUT.shutter |->
    !MULT_CLOCK_EN_OUT && $stable(HGATE_OUT)) else $error("clocks run");
  v1_width_a: assert property ($fell(VGATE_OUT.v1_top) |->
    v1_cnt >= ccdrt_pkg::XFER_CYC && !VGATE_OUT.v1_bottom)
    else $error("short transfer");
  park_idle_a: assert property (VGATE_OUT.row_xfer ||
    VGATE_OUT.v1_top |-> HGATE_OUT == 9'h140) else $error("bad park");
  reset_cover_a: assert property (HGATE_OUT.fg_exit |->
    HGATE_OUT.fg_reset && $past(HGATE_OUT.fg_reset))
    else $error("reset narrow");
  exit_edge_a: assert property ($rose(HGATE_OUT.fg_exit) |->
    (!HGATE_OUT.hsa && !$past(HGATE_OUT.hsa)) ##0 exit_s)
    else $error("exit early");
  pixel_cycle_a: assert property ($rose(HGATE_OUT.hb) |->
    b_half_s ##1 (HGATE_OUT.ha && !HGATE_OUT.hb)) else $error("bad cycle");
  route_one_a: assert property ($rose(HGATE_OUT.hb) |->
    HGATE_OUT.mu_sw ^ HGATE_OUT.lg_sw) else $error("no route");
  route_b_a: assert property (HGATE_OUT.mu_sw |->
    HGATE_OUT.hb && !HGATE_OUT.lg_sw) else $error("bad mult switch");
  route_s_a: assert property (HGATE_OUT.lg_sw |->
    HGATE_OUT.hsb && !HGATE_OUT.mu_sw) else $error("bad low switch");
  sense_once_a: assert property (PART_SENSE_EN_OUT |->
    ps_cnt < ccdrt_pkg::SENSE_CYC) else $error("sense left on");
endmodule // ccdrt_ctrl_chk
bind ccdrt_ctrl ccdrt_ctrl_chk i_ccdrt_ctrl_chk (
  .CLOCK_IN(CLOCK_IN),
  .RST_IN(RST_IN),
  .VGATE_OUT(VGATE_OUT),
  .HGATE_OUT(HGATE_OUT),
  .MULT_CLOCK_EN_OUT(MULT_CLOCK_EN_OUT),
  .PART_SENSE_EN_OUT(PART_SENSE_EN_OUT)
);
`default_nettype wire

// *** ccdrt_sensor_model.sv ***
// behavioural sensor: exposure, charge shift and park faults
`timescale 1ns/100ps
`default_nettype none
module ccdrt_sensor_model (
  // clock and reset
  input  wire logic                       clk_in,
  input  wire logic                       rst_in,
  // gate drive
  input  wire ccdrt_pkg::ccdrt_vgate_type vgate_in,
  input  wire ccdrt_pkg::ccdrt_hgate_type hgate_in,
  // observations
  output var  logic                       expose_out,
  output var  int                         pixels_out,
  output var  int                         faults_out
);
  logic shut_reg;
  logic last_reg;
  // state moves on gate edges; a packet is sensed at each last-gate fall
  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      shut_reg   <= 1'b0;
      last_reg   <= 1'b0;
      expose_out <= 1'b0;
      pixels_out <= 0;
      faults_out <= 0;
    end else begin
      shut_reg <= vgate_in.shutter;
      last_reg <= hgate_in.last;
      if (shut_reg && !vgate_in.shutter) expose_out <= 1'b1;
      if (vgate_in.v1_top) expose_out <= 1'b0;
      if (vgate_in.row_xfer) pixels_out <= 0;
      else if (last_reg && !hgate_in.last)
        pixels_out <= pixels_out + 1;
      // moving the horizontal register while parked would smear charge
      if ((vgate_in.shutter || vgate_in.row_xfer) && hgate_in.hb)
        faults_out <= faults_out + 1;
    end
  end
endmodule // ccdrt_sensor_model
`default_nettype wire

// *** test_ccdrt_ctrl.sv ***
// self-checking bench for the readout sequencer
`timescale 1ns/100ps
`default_nettype none
module test_ccdrt_ctrl;
  localparam logic [15:0] THR = 16'h03A2;
  localparam int          ROWS = 2;
  localparam int          DARK_AT = ccdrt_pkg::DARK_CYC;
  localparam int          ACT_AT = ccdrt_pkg::DARK_CYC + ccdrt_pkg::ACT_CYC;
  logic                       clk = 1'b0;
  logic                       rst = 1'b1;
  logic                       start = 1'b0;
  logic [15:0]                sample = 16'h0000;
  logic                       sample_valid = 1'b0;
  logic                       feed = 1'b0;
  logic                       hb_d = 1'b0;
  logic                       mult_d = 1'b0;
  logic                       ready;
  logic                       mult_en;
  logic                       sense_en;
  logic                       exposing;
  logic                       exp_mu;
  logic                       exp_q[$];
  ccdrt_pkg::ccdrt_vgate_type vgate;
  ccdrt_pkg::ccdrt_hgate_type hgate;
  ccdrt_pkg::ccdrt_stat_type  status;
  int                         pixels;
  int                         faults;
  int                         tot = 0;
  int                         hc = 0;
  int                         lines = 0;
  int                         n_mismatch = 0;
  int                         checks = 0;
  int                         seed = 32'h9B63B819;
  always #12.5 clk = ~clk;
  ccdrt_ctrl #(.ROWS(ROWS), .EXPOSE_CYCLES(10), .THRESH_CODE(THR))
  i_ccdrt_ctrl (
    .CLOCK_IN(clk), .RST_IN(rst), .START_IN(start),
    .SAMPLE_IN(sample), .SAMPLE_VALID_IN(sample_valid),
    .SAMPLE_READY_OUT(ready), .VGATE_OUT(vgate), .HGATE_OUT(hgate),
    .MULT_CLOCK_EN_OUT(mult_en), .PART_SENSE_EN_OUT(sense_en),
    .STATUS_OUT(status)
  );
  ccdrt_sensor_model i_ccdrt_sensor_model (
    .clk_in(clk), .rst_in(rst), .vgate_in(vgate), .hgate_in(hgate),
    .expose_out(exposing), .pixels_out(pixels), .faults_out(faults)
  );
  task automatic cmp_val(input string what, input logic [31:0] exp,
                         input logic [31:0] got);
    checks++;
    if (got !== exp) begin
      n_mismatch++;
      $display("[ERR] %s expected %0h seen %0h", what, exp, got);
    end
  endtask
  task automatic give_verdict;
    if (n_mismatch == 0 && checks > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  // front end: codes crowd the threshold; valid held until taken
  always @(posedge clk) begin
    if (sample_valid && ready) exp_q.push_back(sample < THR);
    if (!sample_valid || ready) begin
      sample_valid <= feed && (($random(seed) & 3) != 0);
      sample <= ($random(seed) & 1) ? THR - 16'h0004
                + 16'($random(seed) & 7) : 16'($random(seed));
    end
  end
  // routing watcher; the first 28 switch settings come from the reset delay line, not from samples
  always @(posedge clk) begin
    hb_d <= hgate.hb;
    mult_d <= mult_en;
    if (hgate.hb && !hb_d) begin
      if (tot >= ccdrt_pkg::ROUTE_DLY) begin
        exp_mu = exp_q.size() > 0 ? exp_q.pop_front() : 1'b0;
        cmp_val("mult switch", exp_mu, hgate.mu_sw);
        cmp_val("low switch", !exp_mu, hgate.lg_sw);
      end
      // status windows follow the horizontal cycle count into the line
      cmp_val("dark", hc >= DARK_AT && hc < ACT_AT, status.dark);
      cmp_val("active", hc >= ACT_AT, status.active);
      tot++;
      hc++;
    end
    if (mult_d && !mult_en) begin
      cmp_val("line cycles", ccdrt_pkg::LINE_CYC, hc);
      lines++;
      hc = 0;
    end
  end
  // hang guard, well beyond one short frame
  initial begin
    repeat (40000) @(posedge clk);
    n_mismatch++;
    give_verdict();
  end
  // main sequence: init, fill to refusal, frame, refused start
  initial begin
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    repeat (2) @(posedge clk);
    cmp_val("sense on", 1, sense_en);
    for (int i = 0; i < 200 && status.busy !== 1'b0; i++) @(posedge clk);
    @(posedge clk);
    cmp_val("sense off", 0, sense_en);
    feed <= 1'b1;
    repeat (40) @(posedge clk);
    cmp_val("fifo ready", 0, ready);
    cmp_val("fifo fill", 8, exp_q.size());
    start <= 1'b1;
    @(posedge clk);
    start <= 1'b0;
    repeat (50) @(posedge clk);
    cmp_val("exposing", 1, exposing);
    repeat (250) @(posedge clk);
    start <= 1'b1;
    @(posedge clk);
    start <= 1'b0;
    for (int i = 0; i < 30000 && !(lines == ROWS - 1 && hc >= 3000); i++)
      @(posedge clk);
    feed <= 1'b0;
    for (int i = 0; i < 2000 && status.frame_done !== 1'b1; i++)
      @(posedge clk);
    cmp_val("frame done", 1, status.frame_done);
    repeat (300) @(posedge clk);
    cmp_val("lines", ROWS, lines);
    cmp_val("pixels", ccdrt_pkg::LINE_CYC, pixels);
    cmp_val("park faults", 0, faults);
    cmp_val("busy", 0, status.busy);
    give_verdict();
  end
endmodule // test_ccdrt_ctrl
`default_nettype wire
